// ### rtl/gpdr_pkg.sv
// Constants for the eight-pin port data registers
package gpdr_pkg;
  localparam int unsigned NPIN = 8;
  localparam int unsigned SCW  = 3;
  localparam int unsigned IDXW = 5;
  localparam int unsigned IDX_LO = 2;
  localparam int unsigned IDX_HI = IDX_LO + IDXW - 1;
  localparam int unsigned SC_TOP = NPIN * SCW - 1;
  // Register indices; byte address is four times the index
  localparam logic [IDXW-1:0] IDX_DIR     = 5'h00;
  localparam logic [IDXW-1:0] IDX_DIR_SET = 5'h01;
  localparam logic [IDXW-1:0] IDX_DIR_CLR = 5'h02;
  localparam logic [IDXW-1:0] IDX_DIR_TGL = 5'h03;
  localparam logic [IDXW-1:0] IDX_LVL     = 5'h04;
  localparam logic [IDXW-1:0] IDX_LVL_SET = 5'h05;
  localparam logic [IDXW-1:0] IDX_LVL_CLR = 5'h06;
  localparam logic [IDXW-1:0] IDX_LVL_TGL = 5'h07;
  localparam logic [IDXW-1:0] IDX_SAMPLED = 5'h08;
  localparam logic [IDXW-1:0] IDX_FLAGS   = 5'h09;
  localparam logic [IDXW-1:0] IDX_SENSE   = 5'h10;
  // Reset values
  localparam logic [NPIN-1:0]   RST_BYTE  = 8'h00;
  localparam logic [SC_TOP:0]   RST_SENSE = 24'h000000;
  localparam logic [31:0]       RD_ZERO   = 32'h00000000;
  // Sense-configuration codes
  localparam logic [SCW-1:0] SC_NOINT = 3'h0;
  localparam logic [SCW-1:0] SC_BOTH  = 3'h1;
  localparam logic [SCW-1:0] SC_RISE  = 3'h2;
  localparam logic [SCW-1:0] SC_FALL  = 3'h3;
  localparam logic [SCW-1:0] SC_INDIS = 3'h4;
  localparam logic [SCW-1:0] SC_LOW   = 3'h5;
  // Bus signalling
  localparam int unsigned HTRANS_ACT = 1;
  localparam logic [1:0]  HRESP_OKAY = 2'h0;
  typedef enum logic [3:0] {
    GPDR_ST_IDLE = 4'b0001,
    GPDR_ST_WR   = 4'b0010,
    GPDR_ST_RD   = 4'b0100,
    GPDR_ST_RDO  = 4'b1000
  } gpdr_state_t;
endpackage

// ### rtl/gpdr_port.sv
// Eight-pin port data registers behind an AHB-Lite slave
//
// Summary of operation
// - Driver-enable bit 0 disables pin output driver, 1 enables it.
// - Driver enable never touches input buffer; only sense code does.
// - Driver-enable-set write: ones set enable bits, zeros ignored.
// - Driver-enable-clear write: ones clear enable bits, zeros ignored.
// - Driver-enable-toggle write: ones invert enable bits, zeros ignored.
// - Reading driver-enable aliases returns the driver-enable register.
// - Drive-level bit sets pin level, visible only while driver enabled.
// - Drive-level-set write: ones set level bits, zeros ignored.
// - Drive-level-clear write: ones clear level bits, zeros ignored.
// - Drive-level-toggle write: ones invert level bits, zeros ignored.
// - Reading drive-level aliases returns the drive-level register.
// - Sampled levels show pins; writing ones there inverts drive levels.
// - With input buffer off, pin is not sampled; bit holds.
// - Event flag sets when pin matches its sense condition.
// - Writing one clears an event flag; zeros ignored.
// - Sense 0 no event buffer on; 1 both, 2 rising, 3 falling edges.
// - Sense 4 disables event and input buffer; codes above 5 reserved.
// - Sense 5 re-raises the flag every cycle while pin stays low.
// - Interrupt request stands while any enabled pin flag is set.
`timescale 1ns/1ps
module gpdr_port (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        clk_en,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic      [1:0]  hresp,
  input  wire logic [7:0]  pin_in,
  output logic      [7:0]  pin_out,
  output logic      [7:0]  pin_oe,
  output logic             irq
);

  localparam int unsigned NP = gpdr_pkg::NPIN;
  localparam int unsigned SW = gpdr_pkg::SCW;
  localparam int unsigned IW = gpdr_pkg::IDXW;

  gpdr_pkg::gpdr_state_t st_q;
  gpdr_pkg::gpdr_state_t st_d;

  logic [IW-1:0]   idx_q;
  logic            accept;
  logic            wr;
  logic [NP-1:0]   wdat;
  logic [31:0]     rd_val;
  logic [31:0]     hrdata_q;
  logic            hreadyout_q;

  logic [NP-1:0]   dir_q;
  logic [NP-1:0]   dir_d;
  logic [NP-1:0]   lvl_q;
  logic [NP-1:0]   lvl_d;
  logic [gpdr_pkg::SC_TOP:0] sense_q;
  logic [gpdr_pkg::SC_TOP:0] sense_d;

  logic [NP-1:0]   sync1_q;
  logic [NP-1:0]   sync2_q;
  logic [NP-1:0]   samp_q;
  logic [NP-1:0]   flag_q;
  logic [NP-1:0]   flag_d;
  logic [NP-1:0]   buf_en;
  logic [NP-1:0]   int_en;
  logic [NP-1:0]   lvl_mode;
  logic [NP-1:0]   ev;
  logic [NP-1:0]   clr;
  logic            irq_q;

  // hsize is not checked: only whole-word transfers are used
  assign accept = hsel & htrans[gpdr_pkg::HTRANS_ACT] & hready;
  assign wr     = (st_q == gpdr_pkg::GPDR_ST_WR);
  assign wdat   = hwdata[NP-1:0];

  // Reads take one wait state so a write in the data phase just
  // before is already stored when the read value is captured
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      gpdr_pkg::GPDR_ST_IDLE,
      gpdr_pkg::GPDR_ST_WR,
      gpdr_pkg::GPDR_ST_RDO: begin
        if (accept) begin
          st_d = hwrite ? gpdr_pkg::GPDR_ST_WR : gpdr_pkg::GPDR_ST_RD;
        end else begin
          st_d = gpdr_pkg::GPDR_ST_IDLE;
        end
      end
      gpdr_pkg::GPDR_ST_RD: begin
        st_d = gpdr_pkg::GPDR_ST_RDO;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q <= gpdr_pkg::GPDR_ST_IDLE;
    end else if (clk_en) begin
      st_q <= st_d;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      idx_q <= gpdr_pkg::IDX_DIR;
    end else if (clk_en && accept) begin
      idx_q <= haddr[gpdr_pkg::IDX_HI:gpdr_pkg::IDX_LO];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout_q <= 1'b1;
    end else if (clk_en) begin
      hreadyout_q <= (st_d != gpdr_pkg::GPDR_ST_RD);
    end
  end

  // Read mux; unmapped indices read as zero
  always_comb begin
    rd_val = gpdr_pkg::RD_ZERO;
    case (idx_q)
      gpdr_pkg::IDX_DIR,
      gpdr_pkg::IDX_DIR_SET,
      gpdr_pkg::IDX_DIR_CLR,
      gpdr_pkg::IDX_DIR_TGL: rd_val[NP-1:0] = dir_q;
      gpdr_pkg::IDX_LVL,
      gpdr_pkg::IDX_LVL_SET,
      gpdr_pkg::IDX_LVL_CLR,
      gpdr_pkg::IDX_LVL_TGL: rd_val[NP-1:0] = lvl_q;
      gpdr_pkg::IDX_SAMPLED: rd_val[NP-1:0] = samp_q;
      gpdr_pkg::IDX_FLAGS:   rd_val[NP-1:0] = flag_q;
      gpdr_pkg::IDX_SENSE:   rd_val[gpdr_pkg::SC_TOP:0] = sense_q;
      default: ;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= gpdr_pkg::RD_ZERO;
    end else if (clk_en && st_q == gpdr_pkg::GPDR_ST_RD) begin
      hrdata_q <= rd_val;
    end
  end

  // Driver enable and its aliases
  always_comb begin
    dir_d = dir_q;
    if (wr) begin
      case (idx_q)
        gpdr_pkg::IDX_DIR:     dir_d = wdat;
        gpdr_pkg::IDX_DIR_SET: dir_d = dir_q | wdat;
        gpdr_pkg::IDX_DIR_CLR: dir_d = dir_q & ~wdat;
        gpdr_pkg::IDX_DIR_TGL: dir_d = dir_q ^ wdat;
        default: ;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dir_q <= gpdr_pkg::RST_BYTE;
    end else if (clk_en) begin
      dir_q <= dir_d;
    end
  end

  // Drive level; a write of ones to the sampled register inverts it
  always_comb begin
    lvl_d = lvl_q;
    if (wr) begin
      case (idx_q)
        gpdr_pkg::IDX_LVL:     lvl_d = wdat;
        gpdr_pkg::IDX_LVL_SET: lvl_d = lvl_q | wdat;
        gpdr_pkg::IDX_LVL_CLR: lvl_d = lvl_q & ~wdat;
        gpdr_pkg::IDX_LVL_TGL: lvl_d = lvl_q ^ wdat;
        gpdr_pkg::IDX_SAMPLED: lvl_d = lvl_q ^ wdat;
        default: ;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lvl_q <= gpdr_pkg::RST_BYTE;
    end else if (clk_en) begin
      lvl_q <= lvl_d;
    end
  end

  always_comb begin
    sense_d = sense_q;
    if (wr && idx_q == gpdr_pkg::IDX_SENSE) begin
      sense_d = hwdata[gpdr_pkg::SC_TOP:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sense_q <= gpdr_pkg::RST_SENSE;
    end else if (clk_en) begin
      sense_q <= sense_d;
    end
  end

  // Pin outputs come straight from the registers; the pad
  // drives the level only while its enable is high
  assign pin_out = lvl_q;
  assign pin_oe  = dir_q;

  // Pins are asynchronous, so two flops before any use
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_q <= gpdr_pkg::RST_BYTE;
      sync2_q <= gpdr_pkg::RST_BYTE;
    end else if (clk_en) begin
      sync1_q <= pin_in;
      sync2_q <= sync1_q;
    end
  end

  assign clr = (wr && idx_q == gpdr_pkg::IDX_FLAGS) ? wdat : '0;

  // Per-pin sense decode; the last sampled level is the edge
  // reference, so a pin re-enabled after sense 4 may see an edge
  for (genvar i = 0; i < NP; i++) begin : g_pin
    logic [SW-1:0] sc;
    assign sc = sense_q[i*SW +: SW];
    assign buf_en[i] = (sc != gpdr_pkg::SC_INDIS);
    assign lvl_mode[i] = (sc == gpdr_pkg::SC_LOW);
    always_comb begin
      ev[i]     = 1'b0;
      int_en[i] = 1'b1;
      case (sc)
        gpdr_pkg::SC_BOTH: ev[i] = sync2_q[i] ^ samp_q[i];
        gpdr_pkg::SC_RISE: ev[i] = sync2_q[i] & ~samp_q[i];
        gpdr_pkg::SC_FALL: ev[i] = ~sync2_q[i] & samp_q[i];
        gpdr_pkg::SC_LOW:  ev[i] = ~sync2_q[i];
        default:           int_en[i] = 1'b0;
      endcase
    end
    // Set wins over a clear in the same cycle
    assign flag_d[i] = ev[i] | (flag_q[i] & ~clr[i]);
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        samp_q[i] <= 1'b0;
      end else if (clk_en && buf_en[i]) begin
        samp_q[i] <= sync2_q[i];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flag_q <= gpdr_pkg::RST_BYTE;
    end else if (clk_en) begin
      flag_q <= flag_d;
    end
  end

  // Registered one cycle behind the flags to keep the output a flop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_q <= 1'b0;
    end else if (clk_en) begin
      irq_q <= |(flag_q & int_en);
    end
  end

  assign irq       = irq_q;
  assign hrdata    = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp     = gpdr_pkg::HRESP_OKAY;

  property p_dir_set;
    @(posedge hclk) disable iff (!hresetn)
    (clk_en && wr && idx_q == gpdr_pkg::IDX_DIR_SET)
    |=> ((pin_oe & $past(wdat)) == $past(wdat));
  endproperty
  a_dir_set: assert property (p_dir_set) else $error("enable set lost");

  property p_dir_clr;
    @(posedge hclk) disable iff (!hresetn)
    (clk_en && wr && idx_q == gpdr_pkg::IDX_DIR_CLR)
    |=> ((pin_oe & $past(wdat)) == '0);
  endproperty
  a_dir_clr: assert property (p_dir_clr) else $error("enable clear lost");

  property p_dir_tgl;
    @(posedge hclk) disable iff (!hresetn)
    (clk_en && wr && idx_q == gpdr_pkg::IDX_DIR_TGL)
    |=> (pin_oe == ($past(pin_oe) ^ $past(wdat)));
  endproperty
  a_dir_tgl: assert property (p_dir_tgl) else $error("enable toggle wrong");

  property p_lvl_tgl;
    @(posedge hclk) disable iff (!hresetn)
    (clk_en && wr && (idx_q == gpdr_pkg::IDX_LVL_TGL
      || idx_q == gpdr_pkg::IDX_SAMPLED))
    |=> (pin_out == ($past(pin_out) ^ $past(wdat)));
  endproperty
  a_lvl_tgl: assert property (p_lvl_tgl) else $error("level toggle wrong");

  property p_lvl_set;
    @(posedge hclk) disable iff (!hresetn)
    (clk_en && wr && idx_q == gpdr_pkg::IDX_LVL_SET)
    |=> ((pin_out & $past(wdat)) == $past(wdat));
  endproperty
  a_lvl_set: assert property (p_lvl_set) else $error("level set lost");

  property p_lvl_clr;
    @(posedge hclk) disable iff (!hresetn)
    (clk_en && wr && idx_q == gpdr_pkg::IDX_LVL_CLR)
    |=> ((pin_out & $past(wdat)) == '0);
  endproperty
  a_lvl_clr: assert property (p_lvl_clr) else $error("level clear lost");

  property p_alias_rd;
    @(posedge hclk) disable iff (!hresetn)
    (clk_en && st_q == gpdr_pkg::GPDR_ST_RD
      && idx_q == gpdr_pkg::IDX_DIR_CLR)
    |=> (hreadyout && hrdata[NP-1:0] == pin_oe);
  endproperty
  a_alias_rd: assert property (p_alias_rd) else $error("alias read wrong");

  property p_hold;
    @(posedge hclk) disable iff (!hresetn)
    (clk_en && !(&buf_en))
    |=> (((samp_q ^ $past(samp_q)) & ~$past(buf_en)) == '0);
  endproperty
  a_hold: assert property (p_hold) else $error("sample moved");

  property p_low_level;
    @(posedge hclk) disable iff (!hresetn)
    (clk_en && |(lvl_mode & ~sync2_q))
    |=> ((flag_q & $past(lvl_mode & ~sync2_q)) == $past(lvl_mode & ~sync2_q));
  endproperty
  a_low_level: assert property (p_low_level) else $error("level event lost");

  property p_quiet;
    @(posedge hclk) disable iff (!hresetn)
    (clk_en && !(&int_en))
    |=> ((flag_q & ~$past(flag_q) & ~$past(int_en)) == '0);
  endproperty
  a_quiet: assert property (p_quiet) else $error("flag without event");

  property p_set_wins;
    @(posedge hclk) disable iff (!hresetn)
    (clk_en && ev[0]) |=> flag_q[0];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost");

  property p_w1c;
    @(posedge hclk) disable iff (!hresetn)
    (clk_en && clr[1] && !ev[1]) |=> !flag_q[1];
  endproperty
  a_w1c: assert property (p_w1c) else $error("flag not cleared");

  property p_irq;
    @(posedge hclk) disable iff (!hresetn)
    (clk_en && flag_q[2] && int_en[2]) |=> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("irq missing");

endmodule

// ### tb/gpdr_pin_model.sv
// External pin model: the levels that the port sees on its eight pins
`timescale 1ns/1ps
module gpdr_pin_model (
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  input  wire logic [7:0] ext_lvl,
  output logic      [7:0] pin_in
);
  // An enabled driver wins over the outside source; contention is not modelled
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_lvl);
endmodule

// ### tb/tb_gpdr_port.sv
// Self-checking bench for the port data registers
`timescale 1ns/1ps
module tb_gpdr_port;
  typedef struct packed {
    logic [4:0] widx;
    logic [7:0] wd;
    logic [4:0] ridx;
    logic [7:0] rd;
    logic [7:0] oe;
    logic [7:0] out;
  } gpdr_row_t;

  logic        hclk;
  logic        hresetn;
  logic        clk_en;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic [1:0]  hresp;
  logic [7:0]  pin_in;
  logic [7:0]  pin_out;
  logic [7:0]  pin_oe;
  logic        irq;
  logic [7:0]  ext_lvl;
  logic [31:0] rv;
  gpdr_row_t   rows [10];
  int          fail_count;
  int          n_tests;

  gpdr_port u_gpdr_port (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .clk_en    (clk_en),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hwdata    (hwdata),
    .hready    (hreadyout),
    .hrdata    (hrdata),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .pin_in    (pin_in),
    .pin_out   (pin_out),
    .pin_oe    (pin_oe),
    .irq       (irq)
  );

  gpdr_pin_model u_gpdr_pin_model (
    .pin_out (pin_out),
    .pin_oe  (pin_oe),
    .ext_lvl (ext_lvl),
    .pin_in  (pin_in)
  );

  always #12.5 hclk = ~hclk;

  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      fail_count++;
    end
  endtask

  // Called at a rising edge or 1ns after one; hready and read data are taken
  // at rising edges, before the slave's own updates of that edge land
  task automatic bus(input logic [4:0] idx, input logic wr, input logic [31:0] wd,
                     output logic [31:0] rd);
    int k;
    hsel   <= 1'b1;
    haddr  <= {25'h0, idx, 2'b00};
    hwrite <= wr;
    htrans <= 2'b10;
    for (int p = 0; p < 2; p++) begin
      k = 0;
      do begin
        @(posedge hclk);
        k++;
      end while (hreadyout !== 1'b1 && k < 64);
      if (hreadyout !== 1'b1) begin
        $display("ERROR bus wait expected %h seen %h", 1'b1, hreadyout);
        fail_count++;
        end_sim();
      end
      rd = hrdata;
      if (p == 0) begin
        htrans <= 2'b00;
        hsel   <= 1'b0;
        hwdata <= wd;
      end
    end
  endtask

  task automatic wr(input logic [4:0] idx, input logic [31:0] wd);
    logic [31:0] d;
    bus(idx, 1'b1, wd, d);
  endtask

  task automatic rdc(input string nm, input logic [4:0] idx, input logic [31:0] e);
    logic [31:0] d;
    bus(idx, 1'b0, 32'h0, d);
    chk(nm, e, d);
  endtask

  task automatic settle();
    repeat (6) @(posedge hclk);
  endtask

  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    clk_en = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    ext_lvl = 8'h00;
    fail_count = 0;
    n_tests = 0;
    rows[0] = '{gpdr_pkg::IDX_DIR, 8'h0f, gpdr_pkg::IDX_DIR, 8'h0f, 8'h0f, 8'h00};
    rows[1] = '{gpdr_pkg::IDX_DIR_SET, 8'h30, gpdr_pkg::IDX_DIR_SET, 8'h3f, 8'h3f, 8'h00};
    rows[2] = '{gpdr_pkg::IDX_DIR_CLR, 8'h05, gpdr_pkg::IDX_DIR_CLR, 8'h3a, 8'h3a, 8'h00};
    rows[3] = '{gpdr_pkg::IDX_DIR_TGL, 8'hc3, gpdr_pkg::IDX_DIR_TGL, 8'hf9, 8'hf9, 8'h00};
    rows[4] = '{gpdr_pkg::IDX_LVL, 8'h11, gpdr_pkg::IDX_LVL, 8'h11, 8'hf9, 8'h11};
    rows[5] = '{gpdr_pkg::IDX_LVL_SET, 8'h82, gpdr_pkg::IDX_LVL_SET, 8'h93, 8'hf9, 8'h93};
    rows[6] = '{gpdr_pkg::IDX_LVL_CLR, 8'h03, gpdr_pkg::IDX_LVL_CLR, 8'h90, 8'hf9, 8'h90};
    rows[7] = '{gpdr_pkg::IDX_LVL_TGL, 8'h0f, gpdr_pkg::IDX_LVL_TGL, 8'h9f, 8'hf9, 8'h9f};
    rows[8] = '{gpdr_pkg::IDX_SAMPLED, 8'hf0, gpdr_pkg::IDX_LVL, 8'h6f, 8'hf9, 8'h6f};
    // Unmapped place: write ignored, read zero
    rows[9] = '{5'h1f, 8'hff, 5'h1f, 8'h00, 8'hf9, 8'h6f};
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int i = 0; i < 10; i++) begin
      rdc("reset value", 5'(i), 32'h0);
    end
    #1;
    chk("reset pins", 32'h0, {15'h0, irq, pin_oe, pin_out});
    chk("response", {30'h0, gpdr_pkg::HRESP_OKAY}, {30'h0, hresp});
    $display("test reset done");
    // Each write is followed at once by a read of the same or related place
    for (int i = 0; i < 10; i++) begin
      wr(rows[i].widx, {24'h0, rows[i].wd});
      rdc("alias read", rows[i].ridx, {24'h0, rows[i].rd});
      #1;
      chk("pins", {16'h0, rows[i].oe, rows[i].out}, {16'h0, pin_oe, pin_out});
    end
    $display("test alias table done");
    // Output pins are sampled too: the driver enable leaves the buffer on
    ext_lvl <= 8'hff;
    settle();
    rdc("sampled high", gpdr_pkg::IDX_SAMPLED, 32'h6f);
    $display("test sampling done");
    wr(gpdr_pkg::IDX_DIR, 32'h0);
    settle();
    // pin0 rise, pin1 fall, pin2 both, pin3 buffer off, pin4 low level, pin5 reserved
    wr(gpdr_pkg::IDX_SENSE, 32'h3585a);
    ext_lvl <= 8'h00;
    settle();
    rdc("flags fall", gpdr_pkg::IDX_FLAGS, 32'h16);
    rdc("sampled held", gpdr_pkg::IDX_SAMPLED, 32'h08);
    rdc("sense read", gpdr_pkg::IDX_SENSE, 32'h3585a);
    #1;
    chk("irq set", 32'h1, {31'h0, irq});
    wr(gpdr_pkg::IDX_FLAGS, 32'hff);
    rdc("level re-raise", gpdr_pkg::IDX_FLAGS, 32'h10);
    ext_lvl <= 8'h1f;
    settle();
    rdc("flags rise", gpdr_pkg::IDX_FLAGS, 32'h15);
    wr(gpdr_pkg::IDX_FLAGS, 32'h01);
    rdc("partial clear", gpdr_pkg::IDX_FLAGS, 32'h14);
    wr(gpdr_pkg::IDX_FLAGS, 32'h14);
    rdc("all clear", gpdr_pkg::IDX_FLAGS, 32'h00);
    #1;
    chk("irq clear", 32'h0, {31'h0, irq});
    $display("test sense done");
    // Clock enable low freezes the synchronisers, so a pin edge waits for it
    clk_en <= 1'b0;
    ext_lvl <= 8'h1b;
    settle();
    clk_en <= 1'b1;
    #1;
    chk("frozen irq", 32'h0, {31'h0, irq});
    settle();
    rdc("flags thawed", gpdr_pkg::IDX_FLAGS, 32'h04);
    #1;
    chk("irq thawed", 32'h1, {31'h0, irq});
    wr(gpdr_pkg::IDX_FLAGS, 32'h04);
    $display("test clock enable done");
    // A second reset in mid-run puts every register back to zero
    wr(gpdr_pkg::IDX_DIR, 32'h5a);
    #1;
    chk("enable before reset", 32'h5a, {24'h0, pin_oe});
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdc("reset again enable", gpdr_pkg::IDX_DIR, 32'h0);
    rdc("reset again sense", gpdr_pkg::IDX_SENSE, 32'h0);
    #1;
    chk("reset again pins", 32'h0, {15'h0, irq, pin_oe, pin_out});
    $display("test mid reset done");
    end_sim();
  end
endmodule
